//--- ascd_defs.svh
`ifndef ASCD_DEFS_SVH
`define ASCD_DEFS_SVH
// ****************************************
// Reset values and timing
// ****************************************
`define ASCD_RESULT_RESET 16'h0000
`define ASCD_DMA_COUNT_RESET 16'h000F
`define ASCD_INPUT_RESET 5'h00
// Conversion time and clock period in ns
`define ASCD_CONVERT_NS 500
`define ASCD_CLK_NS 5
`define ASCD_CONVERT_CYCLES ((`ASCD_CONVERT_NS + `ASCD_CLK_NS - 1) / `ASCD_CLK_NS)
// Scan-enable position within the second control word
`define ASCD_SCAN_ENABLE_BIT 10
`endif

//--- ascd_pkg.sv
package ascd_pkg;
  typedef enum logic [1:0] {
    ASCD_IDLE = 2'b00,
    ASCD_SAMPLE = 2'b01,
    ASCD_CONVERT = 2'b10
  } ascd_phase_type;
  typedef enum logic [0:0] {
    ASCD_WAIT = 1'b0,
    ASCD_MOVE = 1'b1
  } ascd_dma_phase_type;
endpackage

//--- ascd_link_if.sv
interface ascd_link_if;
  logic dmaRequest;
  logic [15:0] resultWord;
  modport converter (output dmaRequest, output resultWord);
  modport dma (input dmaRequest, input resultWord);
endinterface

//--- ascd_converter.sv
// Local design decisions: the plain strobed port.
`include "ascd_defs.svh"
// Summary of operation
// - Auto-sample bit starts acquisition unaided
// - Trigger ends acquisition, starts conversion
// - Each conversion writes result, requests DMA
// - DMA interrupts after transfer count plus one moved results
// - Channels field 00: first channel only
// - Alternate bit 0: primary set always
// - Fixed select field picks input without scan
// - Negative select 0 uses negative reference
// - Scan enable at bit 10 steps inputs
// - Scanning overrides the fixed select field
// - Each bitmap bit includes its input
// - Scan lowest first, then ascending inputs
// - Single input: increment 0000, mode 00
// - Sixteen-input scan: increment 1111, mode 00
// - Simultaneous setting ignored with one channel
// - Buffer split mode zero: one area
// - Sequence continues after buffer-full interrupt
// - Secondary and auxiliary selections have no effect
// - Disable aborts conversion, keeps last result
// - Conversion order: pointer steps one word
module ascd_converter #(
  parameter int CONVERT_CYCLES = `ASCD_CONVERT_CYCLES,
  parameter int INPUTS = 16
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  ascd_link_if.converter link,
  input wire logic module_enable,
  input wire logic auto_sample_enable,
  input wire logic convTrigger,
  input wire logic [1:0] channels_per_sample_sel,
  input wire logic simultaneous_sample_sel,
  input wire logic alternate_input_set_enable,
  input wire logic [15:0] converter_control_two,
  input wire logic [4:0] primary_pos_input_select,
  input wire logic primary_neg_input_select,
  input wire logic [4:0] secondary_pos_input_select,
  input wire logic secondary_neg_input_select,
  input wire logic [INPUTS-1:0] scan_input_bitmap,
  input wire logic [INPUTS-1:0][15:0] analogCode,
  output logic [15:0] conversion_result_word,
  output logic [4:0] posInputSel,
  output logic negUsesReference,
  output logic sampling,
  output logic converting
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    ascd_pkg::ascd_phase_type phase;
    logic [15:0] count;
    logic [4:0] scanIdx;
    logic [4:0] inputSel;
    logic negRef;
    logic [15:0] result;
    logic request;
  } ascd_conv_state_type;
  ascd_conv_state_type state, next_state;
  logic scanOn;
  logic [4:0] firstScan, nextScan;
  logic firstFound, nextFound;
  initial begin
    if (INPUTS < 1 || INPUTS > 16 || CONVERT_CYCLES < 1 || CONVERT_CYCLES > 65535) begin
      $error("ascd_converter: unsupported parameters");
    end
  end
  // Scan enable sits in the second control word
  assign scanOn = converter_control_two[`ASCD_SCAN_ENABLE_BIT];
  // ****************************************
  // Scan walk
  // ****************************************
  always_comb begin
    firstScan = 5'h00;
    nextScan = 5'h00;
    firstFound = 1'b0;
    nextFound = 1'b0;
    for (int i = 0; i < INPUTS; i++) begin
      if (scan_input_bitmap[i] && !firstFound) begin
        firstScan = 5'(i);
        firstFound = 1'b1;
      end
      if (scan_input_bitmap[i] && !nextFound && 5'(i) > state.scanIdx) begin
        nextScan = 5'(i);
        nextFound = 1'b1;
      end
    end
    if (!nextFound) begin
      nextScan = firstScan;
    end
  end
  // ****************************************
  // Sequencer
  // ****************************************
  // Only the first channel and primary set are modelled, so channel count,
  // simultaneous mode and secondary/auxiliary selects never steer anything.
  always_comb begin
    next_state = state;
    next_state.request = 1'b0;
    unique case (state.phase)
      ascd_pkg::ASCD_IDLE: begin
        if (module_enable && auto_sample_enable) begin
          next_state.phase = ascd_pkg::ASCD_SAMPLE;
          next_state.scanIdx = firstScan;
          next_state.inputSel = scanOn ? firstScan : primary_pos_input_select;
          next_state.negRef = !primary_neg_input_select;
        end
      end
      ascd_pkg::ASCD_SAMPLE: begin
        if (!scanOn) begin
          next_state.inputSel = primary_pos_input_select;
        end
        next_state.negRef = !primary_neg_input_select;
        if (!module_enable) begin
          next_state.phase = ascd_pkg::ASCD_IDLE;
        end else if (convTrigger) begin
          next_state.phase = ascd_pkg::ASCD_CONVERT;
          next_state.count = 16'(CONVERT_CYCLES - 1);
        end
      end
      ascd_pkg::ASCD_CONVERT: begin
        if (!module_enable) begin
          next_state.phase = ascd_pkg::ASCD_IDLE;
        end else if (state.count != 16'h0000) begin
          next_state.count = state.count - 16'h0001;
        end else begin
          // One word per result; the DMA side owns the buffer pointer
          next_state.result = analogCode[state.inputSel[3:0]];
          next_state.request = 1'b1;
          if (scanOn) begin
            next_state.scanIdx = nextScan;
            next_state.inputSel = nextScan;
          end
          // Auto-sample restarts unaided, also after buffer full
          next_state.phase = auto_sample_enable ? ascd_pkg::ASCD_SAMPLE
                                                : ascd_pkg::ASCD_IDLE;
        end
      end
      default: next_state.phase = ascd_pkg::ASCD_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '{ascd_pkg::ASCD_IDLE, 16'h0000, `ASCD_INPUT_RESET, `ASCD_INPUT_RESET,
                 1'b1, `ASCD_RESULT_RESET, 1'b0};
    end else begin
      state <= next_state;
    end
  end
  // ****************************************
  // Outputs
  // ****************************************
  assign link.dmaRequest = state.request;
  assign link.resultWord = state.result;
  assign conversion_result_word = state.result;
  assign posInputSel = state.inputSel;
  assign negUsesReference = state.negRef;
  assign sampling = state.phase == ascd_pkg::ASCD_SAMPLE;
  assign converting = state.phase == ascd_pkg::ASCD_CONVERT;
endmodule

//--- ascd_dma.sv
`include "ascd_defs.svh"
module ascd_dma #(
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  ascd_link_if.dma link,
  input wire logic [15:0] dma_transfer_count,
  input wire logic [1:0] dma_addressing_mode,
  input wire logic result_buffer_split_mode,
  input wire logic [3:0] readIndex,
  output logic [15:0] readWord,
  output logic [3:0] writePointer,
  output logic bufferFull
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [DEPTH-1:0][15:0] buffer;
    logic [15:0] moved;
    logic [3:0] ptr;
    logic full;
  } ascd_dma_state_type;
  ascd_dma_state_type state, next_state;
  initial begin
    if (DEPTH != 16) begin
      $error("ascd_dma: pointer sized for sixteen words");
    end
  end
  // Only mode 00 with one area is served; other settings are not decoded.
  always_comb begin
    next_state = state;
    next_state.full = 1'b0;
    if (link.dmaRequest) begin
      next_state.buffer[state.ptr] = link.resultWord;
      if (state.moved >= dma_transfer_count) begin
        next_state.moved = 16'h0000;
        next_state.ptr = 4'h0;
        next_state.full = 1'b1;
      end else begin
        next_state.moved = state.moved + 16'h0001;
        next_state.ptr = state.ptr + 4'h1;
      end
    end
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  assign readWord = state.buffer[readIndex];
  assign writePointer = state.ptr;
  assign bufferFull = state.full;
endmodule

//--- ascd_asserts.sv
module ascd_asserts (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic dmaRequest,
  input wire logic [15:0] resultWord,
  input wire logic sampling,
  input wire logic converting,
  input wire logic bufferFull
);
  // ****************
  // Link checks
  // ****************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_req_single_pulse: assert property (dmaRequest |=> !dmaRequest)
    else $error("transfer request longer than one cycle");
  a_result_with_req: assert property ($changed(resultWord) |-> dmaRequest)
    else $error("result changed without a transfer request");
  a_req_spacing_min: assert property (dmaRequest |=> !dmaRequest [*2])
    else $error("transfer requests closer than one conversion");
  a_req_after_convert: assert property (dmaRequest |-> $past(converting))
    else $error("transfer request without a finished conversion");
  a_convert_ends_req: assert property (($fell(converting) && sampling) |-> dmaRequest)
    else $error("conversion returned to sampling without a request");
  a_full_after_req: assert property (bufferFull |-> $past(dmaRequest))
    else $error("buffer full without a moved result");
  a_full_single_pulse: assert property (bufferFull |=> !bufferFull)
    else $error("buffer full flag longer than one cycle");
endmodule

//--- tb_adc_sequence_scan_dma_control.sv
module tb_adc_sequence_scan_dma_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_b, enable, auto, trig, simSel, scanOn, negSel;
  logic negRef, sampling, converting, bufferFull;
  logic [4:0] sel, altSel, posInputSel;
  logic [15:0] map, result, readWord, count;
  logic [15:0][15:0] code;
  logic [3:0] readIndex, writePointer;
  int n_fail, tests_run;
  // Rows: scan, fixed select, bitmap, first and second input
  logic [31:0] rows [5] = '{{1'b0, 5'h03, 16'hFFFF, 5'h03, 5'h03},
    {1'b0, 5'h00, 16'h0000, 5'h00, 5'h00}, {1'b1, 5'h07, 16'h0120, 5'h05, 5'h08},
    {1'b1, 5'h00, 16'h8001, 5'h00, 5'h0F}, {1'b1, 5'h1F, 16'h0010, 5'h04, 5'h04}};
  ascd_link_if u_ascd_link_if ();
  // Short conversion keeps the run brief
  ascd_converter #(.CONVERT_CYCLES(2)) u_ascd_converter (.ref_clk(ref_clk), .rst_b(rst_b),
    .link(u_ascd_link_if), .module_enable(enable), .auto_sample_enable(auto),
    .convTrigger(trig), .channels_per_sample_sel(2'h0), .simultaneous_sample_sel(simSel),
    .alternate_input_set_enable(1'b0), .converter_control_two({5'h00, scanOn, 10'h000}),
    .primary_pos_input_select(sel), .primary_neg_input_select(negSel),
    .secondary_pos_input_select(altSel), .secondary_neg_input_select(simSel),
    .scan_input_bitmap(map), .analogCode(code), .conversion_result_word(result),
    .posInputSel(posInputSel), .negUsesReference(negRef), .sampling(sampling),
    .converting(converting));
  ascd_dma u_ascd_dma (.ref_clk(ref_clk), .rst_b(rst_b), .link(u_ascd_link_if),
    .dma_transfer_count(count),
    .dma_addressing_mode(2'h0),
    .result_buffer_split_mode(1'b0),
    .readIndex(readIndex), .readWord(readWord), .writePointer(writePointer),
    .bufferFull(bufferFull));
  ascd_asserts u_ascd_asserts (.ref_clk(ref_clk), .rst_b(rst_b),
    .dmaRequest(u_ascd_link_if.dmaRequest), .resultWord(u_ascd_link_if.resultWord),
    .sampling(sampling), .converting(converting), .bufferFull(bufferFull));
  // ****************
  // Tasks
  // ****************
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Bounded wait for sampling (0) or a transfer request (1)
  task automatic waitFor(input int which);
    for (int i = 0; i < 50; i++) begin
      if ((which != 0 ? u_ascd_link_if.dmaRequest : sampling) === 1'b1) return;
      tick;
    end
    n_fail++;
    report_and_stop;
  endtask
  task automatic restart;
    enable <= 1'b0;
    tick;
    enable <= 1'b1;
    tick;
  endtask
  task automatic conv(input logic [4:0] exp);
    waitFor(0);
    chk("input", 16'(posInputSel), 16'(exp));
    chk("negref", 16'(negRef), 16'(!negSel));
    trig <= 1'b1;
    tick;
    trig <= 1'b0;
    chk("converting", 16'(converting), 16'h0001);
    waitFor(1);
    chk("result", result, code[exp[3:0]]);
    chk("link", u_ascd_link_if.resultWord, code[exp[3:0]]);
    tick;
  endtask
  // ****************
  // Stimulus
  // ****************
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    {rst_b, enable, auto, trig, simSel, scanOn, negSel, sel, altSel, map, readIndex} = '0;
    count = 16'h000F;
    n_fail = 0;
    tests_run = 0;
    for (int i = 0; i < 16; i++) code[i] = 16'hA000 + 16'(i);
    repeat (4) tick;
    rst_b <= 1'b1;
    auto <= 1'b1;
    foreach (rows[r]) begin
      {scanOn, sel, map} <= rows[r][31:10];
      altSel <= ~rows[r][30:26];
      simSel <= r[0];
      negSel <= r[1];
      restart;
      conv(rows[r][9:5]);
      conv(rows[r][4:0]);
    end
    // Second reset mid-run, then a full sixteen-input scan
    rst_b <= 1'b0;
    scanOn <= 1'b1;
    map <= 16'hFFFF;
    repeat (4) tick;
    chk("reset result", result, 16'h0000);
    chk("reset pointer", 16'(writePointer), 16'h0000);
    chk("reset negref", 16'(negRef), 16'h0001);
    rst_b <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      conv(5'(i));
      chk("full", 16'(bufferFull), 16'(i == 15));
    end
    chk("wrap pointer", 16'(writePointer), 16'h0000);
    readIndex <= 4'hF;
    tick;
    chk("buffer", readWord, code[15]);
    conv(5'h00);
    chk("pointer", 16'(writePointer), 16'h0001);
    // Abort mid-conversion keeps last result
    waitFor(0);
    trig <= 1'b1;
    tick;
    trig <= 1'b0;
    enable <= 1'b0;
    repeat (4) tick;
    chk("abort result", result, code[0]);
    chk("abort idle", 16'({sampling, converting}), 16'h0000);
    report_and_stop;
  end
endmodule
